// *** src/ubra_pkg.sv ***
// package for the banked uart register map: offsets, fields, codes, structs
// assumes a host bus that is synchronous to i_clk_sys
package ubra_pkg;

   // register addresses on the 3-bit host bus
   localparam logic [2:0] ADR_DIV_LOW    = 3'h0;  // receive/transmit, divisor low, level count
   localparam logic [2:0] ADR_DIV_HIGH   = 3'h1;  // interrupt enable, divisor high, feature
   localparam logic [2:0] ADR_FRAC       = 3'h2;  // status/fifo ctrl, fraction, enhanced fn
   localparam logic [2:0] ADR_LINE_CTRL  = 3'h3;
   localparam logic [2:0] ADR_MODEM_CTRL = 3'h4;
   localparam logic [2:0] ADR_LINE_STAT  = 3'h5;
   localparam logic [2:0] ADR_MODEM_STAT = 3'h6;
   localparam logic [2:0] ADR_SCRATCH    = 3'h7;
   localparam logic [2:0] ADR_FLOW_BASE  = 3'h4;  // first of four flow characters

   // key values, field positions and masks
   localparam logic [7:0] LCR_ENH_KEY    = 8'hBF;
   localparam int         LCR_DIV_BIT    = 7;
   localparam int         EFR_ENH_BIT    = 4;
   localparam int         FCR_FIFO_BIT   = 0;
   localparam int         FCR_RXRST_BIT  = 1;
   localparam int         FCR_TXRST_BIT  = 2;
   localparam int         FEATURE_CONTROL_SWAP_BIT  = 6;
   localparam int         FEATURE_CONTROL_RXTX_BIT  = 7;
   localparam int         IER_RX_BIT     = 0;
   localparam int         IER_TX_BIT     = 1;
   localparam int         IER_LINE_BIT   = 2;
   localparam int         IER_MODEM_BIT  = 3;
   localparam logic [7:0] IER_ENH_MASK   = 8'hF0;
   localparam logic [7:0] FCR_ENH_MASK   = 8'h38;
   localparam logic [7:0] MCR_ENH_MASK   = 8'hE0;
   localparam logic [7:0] FCR_PULSE_MASK = 8'h06;
   localparam logic [7:0] DIV_ZERO       = 8'h00;
   localparam logic [7:0] REG_RST        = 8'h00;
   localparam logic [7:0] LEVEL_EMPTY    = 8'h00;

   // interrupt source codes, status bits 3:0
   localparam logic [3:0] ISR_LINE  = 4'h6;
   localparam logic [3:0] ISR_RXRDY = 4'h4;
   localparam logic [3:0] ISR_TXRDY = 4'h2;
   localparam logic [3:0] ISR_MODEM = 4'h0;
   localparam logic [3:0] ISR_NONE  = 4'h1;

   // register bank selected by the line control value alone
   typedef enum logic [2:0] {
      BANK_NORM = 3'b001,
      BANK_DIV  = 3'b010,
      BANK_ENH  = 3'b100
   } ubra_bank_e;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } ubra_bus_s;

   typedef struct packed {
      logic       brg_sel;
      logic       indep_brg;
      logic       mode_4x;
      logic       mode_8x;
      logic [3:0] fraction;
   } ubra_frac_s;

   typedef struct packed {
      logic       auto_cts;
      logic       auto_rts;
      logic       special_sel;
      logic       enh_en;
      logic [3:0] sw_flow;
   } ubra_efr_s;

   typedef struct packed {
      logic       rxtx_sel;
      logic       swap_scratch;
      logic [1:0] fifo_trigger_level_mode;
      logic       rs485_int;
      logic       ir_rx_inv;
      logic [1:0] rts_delay;
   } ubra_feature_control_s;

   typedef struct packed {
      logic [7:0]      line_ctrl;
      logic [7:0]      int_enable;
      logic [7:0]      fifo_ctrl;
      logic [7:0]      modem_ctrl;
      logic [7:0]      scratch;
      logic [7:0]      div_low;
      logic [7:0]      div_high;
      ubra_frac_s      frac;
      ubra_efr_s       enhanced_function;
      ubra_feature_control_s      feature_control;
      logic [7:0]      fifo_trigger_level;
      logic [3:0][7:0] flow_char;  // resume 1, resume 2, pause 1, pause 2
   } ubra_cfg_s;

endpackage : ubra_pkg

// *** src/ubra_isr.sv ***
// interrupt prioritiser: masks the four classic sources and encodes status
// assumes all inputs come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module ubra_isr (
   input  wire logic [3:0] i_ier,
   input  wire logic       i_fifo_en,
   input  wire logic       i_rx_src,
   input  wire logic       i_tx_src,
   input  wire logic       i_line_src,
   input  wire logic       i_modem_src,
   output logic      [7:0] o_isr,
   output logic            o_pend
);
   // highest unmasked source wins; enhanced status bits 5:4 have no source here
   always_comb begin
      o_isr = {{2{i_fifo_en}}, 2'b00, ubra_pkg::ISR_NONE};
      if (i_line_src && i_ier[ubra_pkg::IER_LINE_BIT]) begin
         o_isr[3:0] = ubra_pkg::ISR_LINE;
      end else if (i_rx_src && i_ier[ubra_pkg::IER_RX_BIT]) begin
         o_isr[3:0] = ubra_pkg::ISR_RXRDY;
      end else if (i_tx_src && i_ier[ubra_pkg::IER_TX_BIT]) begin
         o_isr[3:0] = ubra_pkg::ISR_TXRDY;
      end else if (i_modem_src && i_ier[ubra_pkg::IER_MODEM_BIT]) begin
         o_isr[3:0] = ubra_pkg::ISR_MODEM;
      end
      o_pend = (o_isr[3:0] != ubra_pkg::ISR_NONE);
   end
endmodule : ubra_isr
`default_nettype wire

// *** src/ubra_regs.sv ***
// banked register map of a fifo uart with receive interrupt and data-ready flag
// assumes host bus strobes, receive fifo status and line inputs share i_clk_sys
// reads answer one cycle after the strobe; writes reach o_cfg one cycle after
// no clock enable: every register runs on every edge
//
// Behaviour
// - Address 010 reaches the fractional divisor only with bit 7 set, line control not 0xBF and enhanced enable set.
// - The fractional divisor holds generator select, independent generators, 4X, 8X and a 4-bit fraction.
// - In the divisor bank with both divisor bytes zero, address 001 reads the fixed identification code.
// - Under the same condition, address 000 reads the read-only revision code.
// - Only line control 0xBF lets address 010 reach the enhanced-function register with its flow fields.
// - Enhanced interrupt-enable, fifo-control and modem-control bits and the fraction can be written only with enhanced enable.
// - In the enhanced bank address 000 reads the fifo level count and writes the trigger level.
// - Enhanced address 001 is the feature control register with its six fields.
// - Enhanced addresses 100 to 111 hold resume 1, resume 2, pause 1 and pause 2 characters.
// - The interrupt enable masks receive, transmit-empty, line and modem sources, reported in status.
// - With fifos and receive interrupt enabled, the interrupt rises at the trigger level and drops below it.
// - The receive code shows in status while at trigger and clears with the output below it.
// - Line-status bit 0 sets when a character enters the fifo and clears only when the fifo is empty.

`timescale 1ns/1ps
`default_nettype none
module ubra_regs #(
   parameter logic [7:0] DEV_ID  = 8'h5A,  // arbitrary value
   parameter logic [7:0] DEV_REV = 8'h01   // arbitrary value
) (
   input  wire logic                i_clk_sys,
   input  wire logic                i_nrst,
   input  wire ubra_pkg::ubra_bus_s i_bus,
   input  wire logic [7:0]          i_rhr_data,
   input  wire logic                i_rx_push,
   input  wire logic [7:0]          i_rx_level,
   input  wire logic [7:0]          i_tx_level,
   input  wire logic                i_tx_empty,
   input  wire logic [7:1]          i_line_stat,
   input  wire logic [7:0]          i_modem_stat,
   output logic [7:0]               o_rdata,
   output logic                     o_rvalid,
   output logic                     o_int,
   output logic                     o_rx_pop,
   output logic                     o_tx_push,
   output logic [7:0]               o_tx_data,
   output logic                     o_rx_fifo_rst,
   output logic                     o_tx_fifo_rst,
   output ubra_pkg::ubra_cfg_s      o_cfg
);
   // configuration and bank
   ubra_pkg::ubra_cfg_s  cfg_r;
   ubra_pkg::ubra_cfg_s  cfg_nxt;
   ubra_pkg::ubra_bank_e bank;

   // data-ready flag and read answer
   logic                 dr_r;
   logic                 dr_nxt;
   logic [7:0]           rdata_r;
   logic [7:0]           rdata_nxt;
   logic                 rvalid_r;

   // interrupt and fifo strobes
   logic                 int_r;
   logic                 int_nxt;
   logic                 pop_r;
   logic                 pop_nxt;
   logic                 push_r;
   logic                 push_nxt;
   logic [7:0]           txd_r;
   logic [7:0]           txd_nxt;
   logic                 rxrst_r;
   logic                 txrst_r;
   logic                 rst_rx_nxt;
   logic                 rst_tx_nxt;

   // decoded conditions and status views
   logic                 enh;
   logic                 fifo_en;
   logic                 id_mode;
   logic                 rx_hit;
   logic                 line_src;
   logic                 modem_src;
   logic [7:0]           isr;
   logic                 pend;
   logic [7:0]           fc_sel;
   logic [7:0]           line_stat;

   // enhanced enable, fifo enable and source summaries
   assign enh       = cfg_r.enhanced_function.enh_en;
   assign fifo_en   = cfg_r.fifo_ctrl[ubra_pkg::FCR_FIFO_BIT];
   assign line_stat = {i_line_stat, dr_r};
   assign line_src  = |i_line_stat[4:1];
   assign modem_src = |i_modem_stat[3:0];

   // bank select: enhanced key first, then divisor enable
   // decided on the stored value, so a new line control acts from the next access
   always_comb begin
      if (cfg_r.line_ctrl == ubra_pkg::LCR_ENH_KEY) begin
         bank = ubra_pkg::BANK_ENH;
      end else if (cfg_r.line_ctrl[ubra_pkg::LCR_DIV_BIT]) begin
         bank = ubra_pkg::BANK_DIV;
      end else begin
         bank = ubra_pkg::BANK_NORM;
      end
   end

   // identification view when both divisor bytes are zero
   // a nonzero write to either byte leaves the view at once
   assign id_mode = (bank == ubra_pkg::BANK_DIV) && (cfg_r.div_low == ubra_pkg::DIV_ZERO)
                    && (cfg_r.div_high == ubra_pkg::DIV_ZERO);

   // level count shows receive or transmit fifo as feature bit 7 picks
   assign fc_sel = cfg_r.feature_control.rxtx_sel ? i_tx_level : i_rx_level;

   // receive trigger reached; a zero trigger still needs one character
   // without fifos the data-ready flag alone is the receive source
   assign rx_hit = fifo_en ? ((i_rx_level >= cfg_r.fifo_trigger_level) && (i_rx_level != ubra_pkg::LEVEL_EMPTY))
                           : dr_r;

   // source prioritiser and status code
   // status bits 7:6 follow fifo enable inside the prioritiser
   ubra_isr u_isr (
      .i_ier       (cfg_r.int_enable[3:0]),
      .i_fifo_en   (fifo_en),
      .i_rx_src    (rx_hit),
      .i_tx_src    (i_tx_empty),
      .i_line_src  (line_src),
      .i_modem_src (modem_src),
      .o_isr       (isr),
      .o_pend      (pend)
   );

   // register writes by bank and address
   always_comb begin
      cfg_nxt    = cfg_r;
      push_nxt   = 1'b0;
      txd_nxt    = txd_r;
      rst_rx_nxt = 1'b0;
      rst_tx_nxt = 1'b0;

      // line control answers at 011 in every bank
      if (i_bus.wr) begin
         if (i_bus.addr == ubra_pkg::ADR_LINE_CTRL) begin
            cfg_nxt.line_ctrl = i_bus.wdata;
         end else if (bank == ubra_pkg::BANK_ENH) begin
            if (i_bus.addr == ubra_pkg::ADR_DIV_LOW) begin
               cfg_nxt.fifo_trigger_level = i_bus.wdata;
            end else if (i_bus.addr == ubra_pkg::ADR_DIV_HIGH) begin
               cfg_nxt.feature_control = i_bus.wdata;
            end else if (i_bus.addr == ubra_pkg::ADR_FRAC) begin
               cfg_nxt.enhanced_function = i_bus.wdata;
            end else if (i_bus.addr >= ubra_pkg::ADR_FLOW_BASE) begin
               // low two address bits pick the flow character
               for (int i = 0; i < 4; i++) begin
                  if (i_bus.addr[1:0] == 2'(i)) begin
                     cfg_nxt.flow_char[i] = i_bus.wdata;
                  end
               end
            end
         end else if ((bank == ubra_pkg::BANK_DIV)
                      && (i_bus.addr == ubra_pkg::ADR_DIV_LOW)) begin
            cfg_nxt.div_low = i_bus.wdata;
         end else if ((bank == ubra_pkg::BANK_DIV)
                      && (i_bus.addr == ubra_pkg::ADR_DIV_HIGH)) begin
            cfg_nxt.div_high = i_bus.wdata;
         end else if ((bank == ubra_pkg::BANK_DIV)
                      && (i_bus.addr == ubra_pkg::ADR_FRAC) && enh) begin
            cfg_nxt.frac = i_bus.wdata;
         end else if (i_bus.addr == ubra_pkg::ADR_DIV_LOW) begin
            // normal bank: holding, enables, fifo, modem, scratch
            push_nxt = 1'b1;
            txd_nxt  = i_bus.wdata;
         end else if (i_bus.addr == ubra_pkg::ADR_DIV_HIGH) begin
            cfg_nxt.int_enable = enh ? i_bus.wdata
               : ((cfg_r.int_enable & ubra_pkg::IER_ENH_MASK)
                  | (i_bus.wdata & ~ubra_pkg::IER_ENH_MASK));
         end else if (i_bus.addr == ubra_pkg::ADR_FRAC) begin
            cfg_nxt.fifo_ctrl = (enh ? i_bus.wdata
               : ((cfg_r.fifo_ctrl & ubra_pkg::FCR_ENH_MASK)
                  | (i_bus.wdata & ~ubra_pkg::FCR_ENH_MASK)))
               & ~ubra_pkg::FCR_PULSE_MASK;
            // reset bits only pulse; the stored copy keeps them clear
            rst_rx_nxt = i_bus.wdata[ubra_pkg::FCR_RXRST_BIT];
            rst_tx_nxt = i_bus.wdata[ubra_pkg::FCR_TXRST_BIT];
         end else if (i_bus.addr == ubra_pkg::ADR_MODEM_CTRL) begin
            cfg_nxt.modem_ctrl = enh ? i_bus.wdata
               : ((cfg_r.modem_ctrl & ubra_pkg::MCR_ENH_MASK)
                  | (i_bus.wdata & ~ubra_pkg::MCR_ENH_MASK));
         end else if ((i_bus.addr == ubra_pkg::ADR_SCRATCH)
                      && !cfg_r.feature_control.swap_scratch) begin
            cfg_nxt.scratch = i_bus.wdata;
         end
      end
   end

   // register reads, answered one cycle after the strobe
   always_comb begin
      rdata_nxt = ubra_pkg::REG_RST;
      pop_nxt   = 1'b0;

      // no strobe keeps the last answer on o_rdata
      if (!i_bus.rd) begin
         rdata_nxt = rdata_r;
      end else if (i_bus.addr == ubra_pkg::ADR_LINE_CTRL) begin
         rdata_nxt = cfg_r.line_ctrl;
      end else if (bank == ubra_pkg::BANK_ENH) begin
         if (i_bus.addr == ubra_pkg::ADR_DIV_LOW) begin
            rdata_nxt = fc_sel;
         end else if (i_bus.addr == ubra_pkg::ADR_DIV_HIGH) begin
            rdata_nxt = cfg_r.feature_control;
         end else if (i_bus.addr == ubra_pkg::ADR_FRAC) begin
            rdata_nxt = cfg_r.enhanced_function;
         end else if (i_bus.addr >= ubra_pkg::ADR_FLOW_BASE) begin
            rdata_nxt = cfg_r.flow_char[i_bus.addr[1:0]];
         end
      end else if (id_mode && (i_bus.addr == ubra_pkg::ADR_DIV_LOW)) begin
         // the view replaces the divisor bytes on reads only
         rdata_nxt = DEV_REV;
      end else if (id_mode && (i_bus.addr == ubra_pkg::ADR_DIV_HIGH)) begin
         rdata_nxt = DEV_ID;
      end else if ((bank == ubra_pkg::BANK_DIV)
                   && (i_bus.addr == ubra_pkg::ADR_DIV_LOW)) begin
         rdata_nxt = cfg_r.div_low;
      end else if ((bank == ubra_pkg::BANK_DIV)
                   && (i_bus.addr == ubra_pkg::ADR_DIV_HIGH)) begin
         rdata_nxt = cfg_r.div_high;
      end else if ((bank == ubra_pkg::BANK_DIV)
                   && (i_bus.addr == ubra_pkg::ADR_FRAC) && enh) begin
         rdata_nxt = cfg_r.frac;
      end else if (i_bus.addr == ubra_pkg::ADR_DIV_LOW) begin
         // a normal-bank read of 000 also pops the receive fifo
         rdata_nxt = i_rhr_data;
         pop_nxt   = 1'b1;
      end else if (i_bus.addr == ubra_pkg::ADR_DIV_HIGH) begin
         rdata_nxt = cfg_r.int_enable;
      end else if (i_bus.addr == ubra_pkg::ADR_FRAC) begin
         rdata_nxt = isr;
      end else if (i_bus.addr == ubra_pkg::ADR_MODEM_CTRL) begin
         rdata_nxt = cfg_r.modem_ctrl;
      end else if (i_bus.addr == ubra_pkg::ADR_LINE_STAT) begin
         rdata_nxt = line_stat;
      end else if (i_bus.addr == ubra_pkg::ADR_MODEM_STAT) begin
         rdata_nxt = i_modem_stat;
      end else if (cfg_r.feature_control.swap_scratch) begin
         // swapped scratch shows the level count
         rdata_nxt = fc_sel;
      end else begin
         rdata_nxt = cfg_r.scratch;
      end
   end

   // data-ready flag: a push wins over an empty fifo in the same cycle
   // clears the cycle after the level reads empty with no push
   always_comb begin
      dr_nxt = dr_r;
      if (i_rx_push) begin
         dr_nxt = 1'b1;
      end else if (i_rx_level == ubra_pkg::LEVEL_EMPTY) begin
         dr_nxt = 1'b0;
      end
   end

   // interrupt output follows any pending unmasked source
   // registered once more, so o_int trails the sources by one cycle
   assign int_nxt = pend;

   // state registers
   // reset clears all; line control 0 selects the normal bank
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_r    <= '0;
         dr_r     <= 1'b0;
         rdata_r  <= ubra_pkg::REG_RST;
         rvalid_r <= 1'b0;
         int_r    <= 1'b0;
         pop_r    <= 1'b0;
         push_r   <= 1'b0;
         txd_r    <= ubra_pkg::REG_RST;
         rxrst_r  <= 1'b0;
         txrst_r  <= 1'b0;
      end else begin
         cfg_r    <= cfg_nxt;
         dr_r     <= dr_nxt;
         rdata_r  <= rdata_nxt;
         rvalid_r <= i_bus.rd;
         int_r    <= int_nxt;
         pop_r    <= pop_nxt;
         push_r   <= push_nxt;
         txd_r    <= txd_nxt;
         rxrst_r  <= rst_rx_nxt;
         txrst_r  <= rst_tx_nxt;
      end
   end

   // outputs straight from registers
   // o_cfg carries the whole configuration to the serial side
   assign o_rdata       = rdata_r;
   assign o_rvalid      = rvalid_r;
   assign o_int         = int_r;
   assign o_rx_pop      = pop_r;
   assign o_tx_push     = push_r;
   assign o_tx_data     = txd_r;
   assign o_rx_fifo_rst = rxrst_r;
   assign o_tx_fifo_rst = txrst_r;
   assign o_cfg         = cfg_r;

endmodule : ubra_regs
`default_nettype wire

// *** test/ubra_regs_chk.sv ***
// concurrent checks on the ports of the banked uart register map
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module ubra_regs_chk #(
   parameter logic [7:0] DEV_ID  = 8'h5A,  // arbitrary value
   parameter logic [7:0] DEV_REV = 8'h01   // arbitrary value
) (
   input wire logic                i_clk_sys,
   input wire logic                i_nrst,
   input wire ubra_pkg::ubra_bus_s i_bus,
   input wire logic                i_rx_push,
   input wire logic [7:0]          i_rx_level,
   input wire logic [7:0]          o_rdata,
   input wire logic                o_rvalid,
   input wire logic                o_int,
   input wire logic                o_rx_pop,
   input wire ubra_pkg::ubra_cfg_s o_cfg
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);
   // bank decode from the stored line control
   logic bank_enh;
   logic bank_div;
   logic div_zero;
   assign bank_enh = o_cfg.line_ctrl == ubra_pkg::LCR_ENH_KEY;
   assign bank_div = !bank_enh && o_cfg.line_ctrl[7];
   assign div_zero = bank_div && o_cfg.div_low == 8'h00 && o_cfg.div_high == 8'h00;
   // register accesses
   chk_read_answer: assert property (i_bus.rd |=> o_rvalid)
      else $error("read not answered");
   chk_div_write: assert property (i_bus.wr && i_bus.addr == 3'h0 && bank_div
      |=> o_cfg.div_low == $past(i_bus.wdata)) else $error("divisor low not written");
   chk_id_read: assert property (i_bus.rd && i_bus.addr == 3'h1 && div_zero
      |=> o_rdata == DEV_ID) else $error("identification code wrong");
   chk_rev_read: assert property (i_bus.rd && i_bus.addr == 3'h0 && div_zero
      |=> o_rdata == DEV_REV) else $error("revision code wrong");
   chk_frac_locked: assert property (i_bus.wr && i_bus.addr == 3'h2 && bank_div
      && !o_cfg.enhanced_function.enh_en |=> $stable(o_cfg.frac)) else $error("fraction written while locked");
   chk_efr_key: assert property (i_bus.wr && i_bus.addr == 3'h2 && bank_enh
      |=> o_cfg.enhanced_function == $past(i_bus.wdata)) else $error("enhanced function not written");
   chk_fifo_trigger_level_write: assert property (i_bus.wr && i_bus.addr == 3'h0 && bank_enh
      |=> o_cfg.fifo_trigger_level == $past(i_bus.wdata)) else $error("trigger level not written");
   // receive interrupt and data-ready flag
   chk_int_rise: assert property (o_cfg.fifo_ctrl[0] && o_cfg.int_enable[0]
      && i_rx_level != 8'h00 && i_rx_level >= o_cfg.fifo_trigger_level |=> o_int) else $error("no interrupt");
   chk_int_drop: assert property (o_cfg.fifo_ctrl[0] && o_cfg.int_enable == 8'h01
      && i_rx_level < o_cfg.fifo_trigger_level |=> !o_int) else $error("interrupt below trigger");
   chk_ready_set: assert property (i_rx_push ##1 (i_bus.rd && i_bus.addr == 3'h5
      && !o_cfg.line_ctrl[7]) |=> o_rdata[0]) else $error("data ready not set");
   chk_pop_pulse: assert property (i_bus.rd && i_bus.addr == 3'h0 && !o_cfg.line_ctrl[7]
      |=> o_rx_pop) else $error("no receive pop");
   cov_int: cover property (o_int);
   cov_id: cover property (div_zero && i_bus.rd);
   cov_enh: cover property (bank_enh && i_bus.wr);
endmodule : ubra_regs_chk
bind ubra_regs ubra_regs_chk #(.DEV_ID(DEV_ID), .DEV_REV(DEV_REV)) u_chk (
   .i_clk_sys, .i_nrst, .i_bus, .i_rx_push, .i_rx_level,
   .o_rdata, .o_rvalid, .o_int, .o_rx_pop, .o_cfg);
`default_nettype wire

// *** test/ubra_host.sv ***
// host processor model: single register accesses on the parallel bus
// assumes the read answer comes on o_rvalid within a few cycles
`timescale 1ns/1ps
`default_nettype none
module ubra_host (
   input  wire logic                i_clk_sys,
   input  wire logic                i_rvalid,
   input  wire logic [7:0]          i_rdata,
   output var ubra_pkg::ubra_bus_s  o_bus
);
   initial o_bus = '0;
   // drive one access after an edge, hold it through the taking edge
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic tmo);
      int k;
      @(posedge i_clk_sys);
      #1;
      o_bus = '{rd: !w, wr: w, addr: a, wdata: d};
      @(posedge i_clk_sys);
      #1;
      // released lines show the inverse, not the old value
      o_bus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      q = 8'h00;
      tmo = !w;
      for (k = 0; k < 4 && tmo; k++) begin
         if (i_rvalid === 1'b1) begin
            q = i_rdata;
            tmo = 1'b0;
         end else begin
            @(posedge i_clk_sys);
            #1;
         end
      end
   endtask : acc
endmodule : ubra_host
`default_nettype wire

// *** test/ubra_regs_tb_top.sv ***
// self-checking bench for the banked uart register map
// assumes the host model instance drives the bus; expectations kept here
`timescale 1ns/1ps
`default_nettype none
module ubra_regs_tb_top;
   localparam logic [7:0] ID_T  = 8'h3C;  // arbitrary value
   localparam logic [7:0] REV_T = 8'h07;  // arbitrary value
   logic                i_clk_sys;
   logic                i_nrst;
   ubra_pkg::ubra_bus_s bus;
   ubra_pkg::ubra_cfg_s cfg;
   logic [7:0]          receive_holding, lvl, tlvl, rdata, txd, q, v, d0;
   logic                push, txe, rvalid, oint, pop, tmo, tpush, rrst, trst;
   logic [7:1]          lstat;
   logic [7:0]          mstat;
   logic [31:0]         seed;
   int                  miscompares, tests_run, i, fcq[$];
   logic [7:0] ier_t [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00};
   logic [7:0] isr_t [5] = '{8'hC4, 8'hC2, 8'hC6, 8'hC0, 8'hC1};
   ubra_host host (.i_clk_sys(i_clk_sys), .i_rvalid(rvalid), .i_rdata(rdata), .o_bus(bus));
   ubra_regs #(.DEV_ID(ID_T), .DEV_REV(REV_T)) dut (
      .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_bus(bus), .i_rhr_data(receive_holding),
      .i_rx_push(push), .i_rx_level(lvl), .i_tx_level(tlvl), .i_tx_empty(txe),
      .i_line_stat(lstat), .i_modem_stat(mstat), .o_rdata(rdata), .o_rvalid(rvalid),
      .o_int(oint), .o_rx_pop(pop), .o_tx_push(tpush), .o_tx_data(txd),
      .o_rx_fifo_rst(rrst), .o_tx_fifo_rst(trst), .o_cfg(cfg));
   initial begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   task automatic conclude();
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      host.acc(1'b1, a, d, d0, tmo);
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      host.acc(1'b0, a, 8'h00, d, tmo);
      if (tmo) begin
         miscompares++;
         $display("[ERR] read answer expected 1 seen 0");
         conclude();
      end
   endtask : rd
   task automatic settle();
      repeat (2) @(posedge i_clk_sys);
      #1;
   endtask : settle
   // main sequence, one block per scenario
   initial begin
      {i_nrst, push, txe, lstat, mstat, lvl, tlvl, receive_holding} = '0;
      {miscompares, tests_run} = '0;
      seed = 32'hE667;
      repeat (4) @(posedge i_clk_sys);
      #1 i_nrst = 1'b1;
      rd(3'h3, q); cmp("line_control", 8'h00, q);
      rd(3'h2, q); cmp("interrupt_status", 8'h01, q);
      $display("test reset done");
      wr(3'h3, 8'h80);
      v = rnd() | 8'h01;
      wr(3'h0, v); rd(3'h0, q); cmp("baud_divisor_low", v, q);
      v = rnd();
      wr(3'h1, v); rd(3'h1, q); cmp("baud_divisor_high", v, q);
      wr(3'h2, 8'hF0); cmp("frac locked", 8'h00, cfg.frac);
      wr(3'h0, 8'h00); wr(3'h1, 8'h00);
      rd(3'h1, q); cmp("device_identification", ID_T, q);
      rd(3'h0, q); cmp("device_revision", REV_T, q);
      wr(3'h0, 8'h12); cmp("baud_divisor_low", 8'h12, cfg.div_low);
      $display("test divisor done");
      wr(3'h3, 8'hBF); wr(3'h0, 8'h03);
      cmp("fifo_trigger_level", 8'h03, cfg.fifo_trigger_level);
      cmp("baud_divisor_low", 8'h12, cfg.div_low);
      lvl = rnd(); rd(3'h0, q); cmp("fifo_level_count", lvl, q);
      lvl = 8'h00;
      v = rnd() | 8'h10;
      wr(3'h2, v); rd(3'h2, q); cmp("enhanced_function", v, q);
      cmp("enhanced_function fields", v, cfg.enhanced_function);
      v = rnd() & 8'h3F;
      wr(3'h1, v); rd(3'h1, q); cmp("feature_control", v, q);
      cmp("feature_control fields", v, cfg.feature_control);
      tlvl = rnd(); wr(3'h1, v | 8'h80);
      rd(3'h0, q); cmp("fifo_level_count transmit", tlvl, q);
      wr(3'h1, v);
      for (i = 4; i < 8; i++) begin
         fcq.push_back(rnd());
         wr(3'(i), 8'(fcq[i-4]));
      end
      for (i = 4; i < 8; i++) begin
         rd(3'(i), q); cmp("flow character", 8'(fcq.pop_front()), q);
      end
      wr(3'h3, 8'h80);
      v = rnd();
      wr(3'h2, v); cmp("fractional fields", v, cfg.frac);
      rd(3'h2, q); cmp("fractional_divisor_control", v, q);
      $display("test enhanced done");
      wr(3'h3, 8'h03); wr(3'h1, 8'hF0);
      cmp("interrupt_enable upper", 8'hF0, cfg.int_enable);
      wr(3'h2, 8'h07); cmp("fifo resets", 8'h03, {6'h00, trst, rrst});
      cmp("fifo_control", 8'h01, cfg.fifo_ctrl);
      wr(3'h1, 8'h01);
      v = rnd();
      wr(3'h0, v); cmp("transmit data", v, txd);
      cmp("transmit push", 8'h01, {7'h00, tpush});
      v = rnd(); wr(3'h7, v); rd(3'h7, q); cmp("scratch_register", v, q);
      for (i = 2; i < 5; i++) begin
         lvl = 8'(i % 4 + 2 * (i / 4));
         settle(); cmp("interrupt", {7'h00, i == 3}, {7'h00, oint});
         rd(3'h2, q); cmp("interrupt_status", i == 3 ? 8'hC4 : 8'hC1, q);
      end
      {lvl, txe, lstat, mstat} = {8'h03, 1'b1, 7'h01, 8'h01};
      for (i = 0; i < 5; i++) begin
         wr(3'h1, ier_t[i]); settle();
         cmp("masked interrupt", {7'h00, i != 4}, {7'h00, oint});
         rd(3'h2, q); cmp("interrupt_status", isr_t[i], q);
      end
      {lvl, txe, lstat, mstat} = '0;
      wr(3'h1, 8'h01);
      $display("test interrupt done");
      rd(3'h5, q); cmp("data ready", 8'h00, {7'h00, q[0]});
      @(posedge i_clk_sys);
      #1 {push, lvl} = {1'b1, 8'h01};
      rd(3'h5, q); cmp("data ready", 8'h01, {7'h00, q[0]});
      push = 1'b0;
      receive_holding = rnd();
      rd(3'h0, q); cmp("receive_holding", receive_holding, q);
      cmp("receive pop", 8'h01, {7'h00, pop});
      rd(3'h5, q); cmp("data ready", 8'h01, {7'h00, q[0]});
      lvl = 8'h00;
      settle();
      rd(3'h5, q); cmp("data ready", 8'h00, {7'h00, q[0]});
      $display("test data ready done");
      conclude();
   end
endmodule : ubra_regs_tb_top
`default_nettype wire
